// >>> verilog/csl_config_strap_latch.sv
// Top of the configuration strap latch: capture sequencing, decoded defaults,
// vendor commands, I2C pass-through, memory mode and pre-attach config gate.
// Assumes all inputs synchronous to clk_sys_in; reset covers power-on and pin reset.
//
// Operation
// - Strap drivers tri-stated throughout reset
// - Latch strap levels at reset release
// - Drive strap pins as outputs after capture
// - Two-bit code marks ports 1-3 fixed
// - Suspend indicator polarity follows low strap bit
// - Local power detect uses internal fixed config
// - Charge strap high advertises port charging
// - Both line straps high disable port
// - Low line strap leaves line enabled
// - Vendor hub commands enabled after reset
// - I2C commands forwarded unchanged when enabled
// - Memory over USB only single-ended
// - Memory over SMBus selects any mode
// - SMBus config writes only before attach
// - SMBus select code with SDA high waits, ignores straps
`timescale 1ns/1ps
module csl_config_strap_latch
  import csl_pkg::*;
(
  input wire logic clk_sys_in,
  input wire logic reset_in,
  input wire logic [15:0] strap_pin_in,
  output logic [15:0] strap_pin_out,
  output logic [15:0] strap_pin_oe_n_out,
  input wire logic [15:0] strap_func_in,
  input wire logic suspend_indicator_in,
  input wire logic sda_level_in,
  input wire logic local_power_detect_in,
  input wire logic [2:0] fixed_port_cfg_in,
  output logic [2:0] fixed_port_out,
  output logic [3:0] port_charge_enable_out,
  output logic [3:0] port_line_disable_out,
  output logic smbus_wait_out,
  output logic straps_ignored_out,
  output logic cfg_invalid_out,
  output logic straps_valid_out,
  input wire logic vendor_cmd_valid_in,
  input wire logic [2:0] vendor_cmd_code_in,
  input wire logic vendor_cmd_disable_in,
  output logic vendor_hub_command_enable_out,
  output logic embedded_ctrl_enable_out,
  output logic special_resume_enable_out,
  output logic hub_reset_req_out,
  input wire logic i2c_cmd_valid_in,
  input wire logic [2:0] i2c_cmd_code_in,
  input wire logic [7:0] i2c_cmd_data_in,
  output logic i2c_pass_enable_out,
  output logic i2c_fwd_valid_out,
  output logic [2:0] i2c_fwd_code_out,
  output logic [7:0] i2c_fwd_data_out,
  input wire logic otp_mode_wr_in,
  input wire logic otp_mode_from_smbus_in,
  input wire logic [1:0] otp_mode_sel_in,
  output logic [1:0] otp_mode_out,
  input wire logic smbus_cfg_wr_in,
  input wire logic hub_attached_in,
  output logic smbus_cfg_accept_out,
  output logic smbus_cfg_reject_out
);

  csl_state_t state_reg;
  csl_state_t state_next;
  logic [15:0] strap_latched;
  logic [2:0] dec_fixed;
  logic [3:0] dec_charge;
  logic [3:0] dec_disable;
  logic dec_susp_low;
  logic dec_smbus_wait;
  logic dec_ignored;
  logic dec_invalid;
  logic [2:0] fixed_reg;
  logic [3:0] charge_reg;
  logic [3:0] disable_reg;
  logic smbus_wait_reg;
  logic ignored_reg;
  logic invalid_reg;
  logic valid_reg;
  logic vendor_en_reg;
  logic ec_en_reg;
  logic resume_en_reg;
  logic hub_reset_reg;
  logic pass_en_reg;
  logic fwd_valid_reg;
  logic [2:0] fwd_code_reg;
  logic [7:0] fwd_data_reg;
  logic [1:0] otp_mode_reg;
  logic cfg_accept_reg;
  logic cfg_reject_reg;

  // ----------------------------------------
  // Capture sequencing
  // ----------------------------------------
  wire capture = (state_reg == ST_CAPTURE);
  wire running = (state_reg == ST_RUN);

  always_comb begin
    case (state_reg)
      ST_CAPTURE: state_next = ST_RUN;
      ST_RUN: state_next = ST_RUN;
      default: state_next = ST_CAPTURE;
    endcase
  end

  always_ff @(posedge clk_sys_in) begin
    if (reset_in) begin
      state_reg <= ST_CAPTURE;
    end else begin
      state_reg <= state_next;
    end
  end

  // Suspend pin carries the indicator at the strapped polarity
  wire [15:0] pin_func;
  assign pin_func = {strap_func_in[15:1],
    suspend_indicator_in ^ dec_susp_low};

  csl_strap_pad u_pad (
    .clk_sys_in(clk_sys_in),
    .reset_in(reset_in),
    .capture_in(capture),
    .pin_in(strap_pin_in),
    .func_in(pin_func),
    .pin_out(strap_pin_out),
    .pin_oe_n_out(strap_pin_oe_n_out),
    .strap_out(strap_latched)
  );

  csl_strap_decode u_decode (
    .strap_in(strap_latched),
    .sda_level_in(sda_level_in),
    .local_power_detect_in(local_power_detect_in),
    .fixed_port_cfg_in(fixed_port_cfg_in),
    .fixed_port_out(dec_fixed),
    .charge_enable_out(dec_charge),
    .line_disable_out(dec_disable),
    .suspend_active_low_out(dec_susp_low),
    .smbus_wait_out(dec_smbus_wait),
    .straps_ignored_out(dec_ignored),
    .cfg_invalid_out(dec_invalid)
  );

  // ----------------------------------------
  // Decoded defaults
  // ----------------------------------------
  always_ff @(posedge clk_sys_in) begin
    if (reset_in || !running) begin
      fixed_reg <= 3'h0;
      charge_reg <= 4'h0;
      disable_reg <= 4'h0;
      smbus_wait_reg <= 1'h0;
      ignored_reg <= 1'h0;
      invalid_reg <= 1'h0;
      valid_reg <= 1'h0;
    end else begin
      fixed_reg <= dec_fixed;
      charge_reg <= dec_charge;
      disable_reg <= dec_disable;
      smbus_wait_reg <= dec_smbus_wait;
      ignored_reg <= dec_ignored;
      invalid_reg <= dec_invalid;
      valid_reg <= 1'h1;
    end
  end

  // ----------------------------------------
  // Vendor hub commands
  // ----------------------------------------
  wire vcmd_go = vendor_cmd_valid_in && vendor_en_reg && !vendor_cmd_disable_in;

  always_ff @(posedge clk_sys_in) begin
    if (reset_in) begin
      vendor_en_reg <= CSL_VENDOR_EN_RESET;
      ec_en_reg <= 1'h0;
      resume_en_reg <= 1'h0;
      hub_reset_reg <= 1'h0;
    end else begin
      if (vendor_cmd_disable_in) begin
        vendor_en_reg <= 1'h0;
      end
      hub_reset_reg <= vcmd_go && (vendor_cmd_code_in == CSL_VCMD_HUB_RESET);
      if (vcmd_go && vendor_cmd_code_in == CSL_VCMD_EC_ON) begin
        ec_en_reg <= 1'h1;
      end
      if (vcmd_go && vendor_cmd_code_in == CSL_VCMD_EC_OFF) begin
        ec_en_reg <= 1'h0;
      end
      if (vcmd_go && vendor_cmd_code_in == CSL_VCMD_RESUME_ON) begin
        resume_en_reg <= 1'h1;
      end
      if (vcmd_go && vendor_cmd_code_in == CSL_VCMD_RESUME_OFF) begin
        resume_en_reg <= 1'h0;
      end
    end
  end

  // ----------------------------------------
  // I2C pass-through
  // ----------------------------------------
  wire pass_on = i2c_cmd_valid_in && (i2c_cmd_code_in == CSL_I2C_PASS_ON);
  wire pass_off = i2c_cmd_valid_in && (i2c_cmd_code_in == CSL_I2C_PASS_OFF);
  wire pass_fwd = i2c_cmd_valid_in && pass_en_reg && !pass_on && !pass_off;

  always_ff @(posedge clk_sys_in) begin
    if (reset_in) begin
      pass_en_reg <= 1'h0;
      fwd_valid_reg <= 1'h0;
      fwd_code_reg <= 3'h0;
      fwd_data_reg <= 8'h00;
    end else begin
      if (pass_on) begin
        pass_en_reg <= 1'h1;
      end else if (pass_off) begin
        pass_en_reg <= 1'h0;
      end
      fwd_valid_reg <= pass_fwd;
      if (pass_fwd) begin
        fwd_code_reg <= i2c_cmd_code_in;
        fwd_data_reg <= i2c_cmd_data_in;
      end
    end
  end

  // ----------------------------------------
  // Memory mode and SMBus config gate
  // ----------------------------------------
  wire [1:0] otp_mode_sel = otp_mode_from_smbus_in ? otp_mode_sel_in : CSL_OTP_SINGLE;

  always_ff @(posedge clk_sys_in) begin
    if (reset_in) begin
      otp_mode_reg <= CSL_OTP_SINGLE;
      cfg_accept_reg <= 1'h0;
      cfg_reject_reg <= 1'h0;
    end else begin
      if (otp_mode_wr_in) begin
        otp_mode_reg <= otp_mode_sel;
      end
      cfg_accept_reg <= smbus_cfg_wr_in && !hub_attached_in;
      cfg_reject_reg <= smbus_cfg_wr_in && hub_attached_in;
    end
  end

  // ----------------------------------------
  // Outputs
  // ----------------------------------------
  assign fixed_port_out = fixed_reg;
  assign port_charge_enable_out = charge_reg;
  assign port_line_disable_out = disable_reg;
  assign smbus_wait_out = smbus_wait_reg;
  assign straps_ignored_out = ignored_reg;
  assign cfg_invalid_out = invalid_reg;
  assign straps_valid_out = valid_reg;
  assign vendor_hub_command_enable_out = vendor_en_reg;
  assign embedded_ctrl_enable_out = ec_en_reg;
  assign special_resume_enable_out = resume_en_reg;
  assign hub_reset_req_out = hub_reset_reg;
  assign i2c_pass_enable_out = pass_en_reg;
  assign i2c_fwd_valid_out = fwd_valid_reg;
  assign i2c_fwd_code_out = fwd_code_reg;
  assign i2c_fwd_data_out = fwd_data_reg;
  assign otp_mode_out = otp_mode_reg;
  assign smbus_cfg_accept_out = cfg_accept_reg;
  assign smbus_cfg_reject_out = cfg_reject_reg;

  // ----------------------------------------
  // Assertions
  // ----------------------------------------
  property p_tristate_in_reset;
    @(posedge clk_sys_in) reset_in |=> (strap_pin_oe_n_out == 16'hffff);
  endproperty
  a_tristate_in_reset: assert property (p_tristate_in_reset)
    else $error("strap pin driven during reset");

  property p_capture_levels;
    @(posedge clk_sys_in) disable iff (reset_in)
    capture |=> (strap_latched == $past(strap_pin_in));
  endproperty
  a_capture_levels: assert property (p_capture_levels)
    else $error("strap level not latched at release");

  property p_drive_after_capture;
    @(posedge clk_sys_in) disable iff (reset_in)
    $fell(reset_in) ##0 capture |=> (strap_pin_oe_n_out == 16'h0000) [*3];
  endproperty
  a_drive_after_capture: assert property (p_drive_after_capture)
    else $error("strap pin not driven after capture");

  property p_fixed_decode;
    @(posedge clk_sys_in) disable iff (reset_in)
    (running && !dec_ignored && !local_power_detect_in) |=>
      (fixed_port_out == {&$past(strap_latched[1:0]), $past(strap_latched[1]),
                          |$past(strap_latched[1:0])});
  endproperty
  a_fixed_decode: assert property (p_fixed_decode)
    else $error("fixed port mask wrong");

  property p_suspend_polarity;
    @(posedge clk_sys_in) disable iff (reset_in)
    running ##1 running |=>
      (strap_pin_out[0] == ($past(suspend_indicator_in) ^ strap_latched[0]));
  endproperty
  a_suspend_polarity: assert property (p_suspend_polarity)
    else $error("suspend indicator polarity wrong");

  property p_local_power;
    @(posedge clk_sys_in) disable iff (reset_in)
    (running && local_power_detect_in && !dec_ignored) |=>
      (fixed_port_out == $past(fixed_port_cfg_in));
  endproperty
  a_local_power: assert property (p_local_power)
    else $error("fixed port not from internal config");

  property p_charge_enable;
    @(posedge clk_sys_in) disable iff (reset_in)
    (running && !dec_ignored) |=> (port_charge_enable_out == $past(strap_latched[7:4]));
  endproperty
  a_charge_enable: assert property (p_charge_enable)
    else $error("charge enable not from strap");

  property p_line_disable;
    @(posedge clk_sys_in) disable iff (reset_in)
    (running && !dec_ignored) |=>
      (port_line_disable_out == ($past(strap_latched[11:8]) & $past(strap_latched[15:12])));
  endproperty
  a_line_disable: assert property (p_line_disable)
    else $error("line disable not both straps high");

  property p_vendor_default;
    @(posedge clk_sys_in) $fell(reset_in) |-> vendor_hub_command_enable_out;
  endproperty
  a_vendor_default: assert property (p_vendor_default)
    else $error("vendor commands not enabled after reset");

  property p_i2c_forward;
    @(posedge clk_sys_in) disable iff (reset_in)
    (i2c_cmd_valid_in && i2c_pass_enable_out && i2c_cmd_code_in > 3'h1) |=>
      (i2c_fwd_valid_out && i2c_fwd_data_out == $past(i2c_cmd_data_in));
  endproperty
  a_i2c_forward: assert property (p_i2c_forward)
    else $error("i2c command not forwarded");

  property p_otp_usb_single;
    @(posedge clk_sys_in) disable iff (reset_in)
    (otp_mode_wr_in && !otp_mode_from_smbus_in) |=> (otp_mode_out == 2'h0);
  endproperty
  a_otp_usb_single: assert property (p_otp_usb_single)
    else $error("usb memory mode not single-ended");

  property p_otp_smbus_mode;
    @(posedge clk_sys_in) disable iff (reset_in)
    (otp_mode_wr_in && otp_mode_from_smbus_in) |=> (otp_mode_out == $past(otp_mode_sel_in));
  endproperty
  a_otp_smbus_mode: assert property (p_otp_smbus_mode)
    else $error("smbus memory mode not taken");

  property p_cfg_gate;
    @(posedge clk_sys_in) disable iff (reset_in)
    smbus_cfg_wr_in |=> (smbus_cfg_accept_out == !$past(hub_attached_in)) &&
      (smbus_cfg_reject_out == $past(hub_attached_in));
  endproperty
  a_cfg_gate: assert property (p_cfg_gate)
    else $error("smbus config accepted after attach");

  property p_smbus_wait;
    @(posedge clk_sys_in) disable iff (reset_in)
    (running && strap_latched[3:2] == 2'h1 && sda_level_in) |=>
      (smbus_wait_out && port_charge_enable_out == 4'h0 && fixed_port_out == 3'h0);
  endproperty
  a_smbus_wait: assert property (p_smbus_wait)
    else $error("smbus wait not honoured");

  property p_straps_hold;
    @(posedge clk_sys_in) disable iff (reset_in)
    running |=> $stable(strap_latched);
  endproperty
  a_straps_hold: assert property (p_straps_hold)
    else $error("latched straps changed");

  c_capture: cover property (@(posedge clk_sys_in) $fell(reset_in) ##1 running);
  c_smbus_wait: cover property (@(posedge clk_sys_in) smbus_wait_out);
  c_port_disabled: cover property (@(posedge clk_sys_in) port_line_disable_out != 4'h0);
  c_cfg_reject: cover property (@(posedge clk_sys_in) smbus_cfg_reject_out);

endmodule

// >>> verilog/csl_pkg.sv
// Package of constants for the configuration strap latch.
// Assumes a single 10 MHz core clock and a synchronous active-high reset.
package csl_pkg;

  // ----------------------------------------
  // Strap pin layout
  // ----------------------------------------
  localparam int CSL_NUM_PINS = 16;
  localparam int CSL_NUM_PORTS = 4;
  localparam int CSL_FIXED_LSB = 0;
  localparam int CSL_CFG_LSB = 2;
  localparam int CSL_CHG_LSB = 4;
  localparam int CSL_DM_LSB = 8;
  localparam int CSL_DP_LSB = 12;
  localparam int CSL_SUSPEND_PIN = 0;

  // ----------------------------------------
  // Reset values
  // ----------------------------------------
  localparam logic [15:0] CSL_OE_N_RESET = 16'hffff;
  localparam logic [15:0] CSL_STRAP_RESET = 16'h0000;
  localparam logic [15:0] CSL_PIN_OUT_RESET = 16'h0000;
  localparam logic CSL_VENDOR_EN_RESET = 1'h1;

  // ----------------------------------------
  // Configuration select codes
  // ----------------------------------------
  localparam logic [1:0] CSL_CFG_SELF = 2'h0;
  localparam logic [1:0] CSL_CFG_SMBUS = 2'h1;
  localparam logic [1:0] CSL_CFG_BUS = 2'h2;
  localparam logic [1:0] CSL_CFG_EEPROM = 2'h3;

  // ----------------------------------------
  // Vendor hub command codes
  // ----------------------------------------
  localparam logic [2:0] CSL_VCMD_EC_ON = 3'h0;
  localparam logic [2:0] CSL_VCMD_EC_OFF = 3'h1;
  localparam logic [2:0] CSL_VCMD_RESUME_ON = 3'h2;
  localparam logic [2:0] CSL_VCMD_RESUME_OFF = 3'h3;
  localparam logic [2:0] CSL_VCMD_HUB_RESET = 3'h4;

  // ----------------------------------------
  // Pass-through I2C command codes
  // ----------------------------------------
  localparam logic [2:0] CSL_I2C_PASS_ON = 3'h0;
  localparam logic [2:0] CSL_I2C_PASS_OFF = 3'h1;

  // ----------------------------------------
  // Memory operating modes
  // ----------------------------------------
  localparam logic [1:0] CSL_OTP_SINGLE = 2'h0;
  localparam logic [1:0] CSL_OTP_DIFF = 2'h1;
  localparam logic [1:0] CSL_OTP_REDUNDANT = 2'h2;
  localparam logic [1:0] CSL_OTP_DIFF_REDUNDANT = 2'h3;

  typedef enum logic [0:0] {ST_CAPTURE, ST_RUN} csl_state_t;

  // Fixed-port mask for ports 3..1 from the two-bit strap code
  function automatic logic [2:0] csl_fixed_mask(input logic [1:0] code);
    csl_fixed_mask = {&code, code[1], |code};
  endfunction

endpackage

// >>> verilog/csl_strap_pad.sv
// Strap pin pad control and capture register.
// Assumes the pins have pull resistors only and reach their level before reset release.
`timescale 1ns/1ps
module csl_strap_pad
  import csl_pkg::*;
(
  input wire logic clk_sys_in,
  input wire logic reset_in,
  input wire logic capture_in,
  input wire logic [15:0] pin_in,
  input wire logic [15:0] func_in,
  output logic [15:0] pin_out,
  output logic [15:0] pin_oe_n_out,
  output logic [15:0] strap_out
);

  logic [15:0] oe_n_reg;
  logic [15:0] strap_reg;
  logic [15:0] pin_reg;

  // ----------------------------------------
  // Capture and drive
  // ----------------------------------------
  always_ff @(posedge clk_sys_in) begin
    if (reset_in) begin
      oe_n_reg <= CSL_OE_N_RESET;
      strap_reg <= CSL_STRAP_RESET;
    end else if (capture_in) begin
      strap_reg <= pin_in;
      oe_n_reg <= '0;
    end
  end

  always_ff @(posedge clk_sys_in) begin
    if (reset_in) begin
      pin_reg <= CSL_PIN_OUT_RESET;
    end else begin
      pin_reg <= func_in;
    end
  end

  assign pin_out = pin_reg;
  assign pin_oe_n_out = oe_n_reg;
  assign strap_out = strap_reg;

endmodule

// >>> verilog/csl_strap_decode.sv
// Decode of latched strap values into feature defaults.
// Assumes the strap vector is stable once captured.
`timescale 1ns/1ps
module csl_strap_decode
  import csl_pkg::*;
(
  input wire logic [15:0] strap_in,
  input wire logic sda_level_in,
  input wire logic local_power_detect_in,
  input wire logic [2:0] fixed_port_cfg_in,
  output logic [2:0] fixed_port_out,
  output logic [3:0] charge_enable_out,
  output logic [3:0] line_disable_out,
  output logic suspend_active_low_out,
  output logic smbus_wait_out,
  output logic straps_ignored_out,
  output logic cfg_invalid_out
);

  wire [1:0] fixed_port_strap = strap_in[CSL_FIXED_LSB +: 2];
  wire [1:0] cfg_code = strap_in[CSL_CFG_LSB +: 2];
  wire [3:0] port_charge_enable_strap = strap_in[CSL_CHG_LSB +: 4];
  wire [3:0] port_minus_line_disable = strap_in[CSL_DM_LSB +: 4];
  wire [3:0] port_plus_line_disable = strap_in[CSL_DP_LSB +: 4];
  wire eeprom_load = (cfg_code == CSL_CFG_EEPROM) && sda_level_in;

  // ----------------------------------------
  // Decode
  // ----------------------------------------
  assign smbus_wait_out = (cfg_code == CSL_CFG_SMBUS) && sda_level_in;
  assign cfg_invalid_out = (cfg_code == CSL_CFG_SMBUS) && !sda_level_in;
  assign straps_ignored_out = smbus_wait_out || eeprom_load;
  assign suspend_active_low_out = fixed_port_strap[0];
  assign fixed_port_out = straps_ignored_out ? 3'h0 :
    local_power_detect_in ? fixed_port_cfg_in :
    csl_fixed_mask(fixed_port_strap);
  assign charge_enable_out = straps_ignored_out ? 4'h0 : port_charge_enable_strap;
  assign line_disable_out = straps_ignored_out ? 4'h0 :
    (port_minus_line_disable & port_plus_line_disable);

endmodule

// >>> tb/csl_strap_board.sv
// Board side of the strap pins: pull resistors only.
// Assumes the device enables are active low and pulls stay put across a reset.
`timescale 1ns/1ps
module csl_strap_board (
  input wire logic [15:0] pull_in,
  input wire logic [15:0] drive_in,
  input wire logic [15:0] oe_n_in,
  output logic [15:0] level_out
);
  // ----------------------------------------
  // Wire level
  // ----------------------------------------
  // Released pin sits at its pull level, board never drives
  assign level_out = (drive_in & ~oe_n_in) | (pull_in & oe_n_in);
endmodule

// >>> tb/tb.sv
// Testbench of the configuration strap latch.
// Assumes a 10 MHz clock and inputs driven 10 ns after each rising edge.
`timescale 1ns/1ps
module tb;
  import csl_pkg::*;
  logic clk_sys_in = 1'b0;
  logic reset_in = 1'b1;
  logic [15:0] pull = 16'h0000;
  logic [15:0] func = 16'h5a3c;
  logic [15:0] lvl;
  logic [15:0] drv;
  logic [15:0] oe_n;
  logic susp = 1'b0;
  logic sda = 1'b0;
  logic lpd = 1'b0;
  logic [2:0] fcfg = 3'h0;
  logic [2:0] fixed;
  logic [3:0] chg;
  logic [3:0] dis;
  logic swait, ign, inval, valid, ven, ec, res, hrst, i2c_en, fv, acc, rej;
  logic vv = 1'b0;
  logic vdis = 1'b0;
  logic iv = 1'b0;
  logic ow = 1'b0;
  logic osm = 1'b0;
  logic sw = 1'b0;
  logic att = 1'b0;
  logic [2:0] vcode = 3'h0;
  logic [2:0] icode = 3'h0;
  logic [7:0] idata = 8'h00;
  logic [1:0] osel = 2'h0;
  logic [2:0] fcode;
  logic [7:0] fdata;
  logic [1:0] otp;
  int n_mismatch = 0;
  int total_checks = 0;

  always #50 clk_sys_in = ~clk_sys_in;

  csl_strap_board board (.pull_in(pull), .drive_in(drv), .oe_n_in(oe_n), .level_out(lvl));

  csl_config_strap_latch DUT (.clk_sys_in(clk_sys_in), .reset_in(reset_in),
    .strap_pin_in(lvl), .strap_pin_out(drv), .strap_pin_oe_n_out(oe_n),
    .strap_func_in(func), .suspend_indicator_in(susp), .sda_level_in(sda),
    .local_power_detect_in(lpd), .fixed_port_cfg_in(fcfg), .fixed_port_out(fixed),
    .port_charge_enable_out(chg), .port_line_disable_out(dis), .smbus_wait_out(swait),
    .straps_ignored_out(ign), .cfg_invalid_out(inval), .straps_valid_out(valid),
    .vendor_cmd_valid_in(vv), .vendor_cmd_code_in(vcode), .vendor_cmd_disable_in(vdis),
    .vendor_hub_command_enable_out(ven), .embedded_ctrl_enable_out(ec),
    .special_resume_enable_out(res), .hub_reset_req_out(hrst),
    .i2c_cmd_valid_in(iv), .i2c_cmd_code_in(icode), .i2c_cmd_data_in(idata),
    .i2c_pass_enable_out(i2c_en), .i2c_fwd_valid_out(fv), .i2c_fwd_code_out(fcode),
    .i2c_fwd_data_out(fdata), .otp_mode_wr_in(ow), .otp_mode_from_smbus_in(osm),
    .otp_mode_sel_in(osel), .otp_mode_out(otp), .smbus_cfg_wr_in(sw),
    .hub_attached_in(att), .smbus_cfg_accept_out(acc), .smbus_cfg_reject_out(rej));

  // ----------------------------------------
  // Shared tasks
  // ----------------------------------------
  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    total_checks++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("mismatch t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic tick();
    @(posedge clk_sys_in);
    #10;
  endtask

  task automatic boot(input logic [15:0] p);
    reset_in = 1'b1;
    pull = p;
    repeat (12) tick();
    chk(oe_n, 16'hffff);
    reset_in = 1'b0;
    tick();
    tick();
    chk(oe_n, 16'h0000);
    chk(16'(valid), 16'h1);
  endtask

  task automatic vcmd(input logic [2:0] code);
    vv = 1'b1;
    vcode = code;
    tick();
  endtask

  task automatic icmd(input logic [2:0] code, input logic [7:0] d);
    iv = 1'b1;
    icode = code;
    idata = d;
    tick();
  endtask

  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  task automatic t_straps();
    for (int c = 0; c < 4; c++) begin
      logic [3:0] ce;
      ce = 4'h1 << c;
      boot({4'h6, 4'ha, ce, 2'b00, c[1:0]});
      chk(16'(fixed), 16'((1 << c) - 1));
      chk(16'(chg), 16'(ce));
      chk(16'(dis), 16'h2);
      chk({drv[15:1], 1'b0}, {func[15:1], 1'b0});
      susp = 1'b1;
      tick();
      chk(16'(drv[0]), {15'h0000, ~c[0]});
      susp = 1'b0;
      tick();
      chk(16'(drv[0]), 16'(c[0]));
      pull = ~pull;
      lpd = 1'b1;
      fcfg = 3'h2;
      tick();
      tick();
      chk(16'(fixed), 16'h2);
      chk(16'(chg), 16'(ce));
      lpd = 1'b0;
    end
  endtask

  task automatic t_select();
    sda = 1'b1;
    boot(16'h00f5);
    chk({swait, ign, chg, fixed}, 16'h0180);
    sda = 1'b0;
    boot(16'h0004);
    chk(16'(inval), 16'h1);
    sda = 1'b1;
    boot(16'h00fe);
    chk({swait, ign, chg, fixed}, 16'h0080);
    boot(16'h00fa);
    chk({swait, ign, chg, fixed}, 16'h007b);
    sda = 1'b0;
  endtask

  task automatic t_commands();
    boot(16'h0000);
    chk(16'(ven), 16'h1);
    vcmd(CSL_VCMD_EC_ON);
    chk(16'(ec), 16'h1);
    vcmd(CSL_VCMD_RESUME_ON);
    chk(16'(res), 16'h1);
    vcmd(CSL_VCMD_EC_OFF);
    chk(16'(ec), 16'h0);
    vcmd(CSL_VCMD_RESUME_OFF);
    chk(16'(res), 16'h0);
    vcmd(CSL_VCMD_HUB_RESET);
    vv = 1'b0;
    chk(16'(hrst), 16'h1);
    vdis = 1'b1;
    tick();
    chk(16'(hrst), 16'h0);
    vdis = 1'b0;
    vcmd(CSL_VCMD_EC_ON);
    vv = 1'b0;
    chk({ven, ec}, 16'h0);
    icmd(CSL_I2C_PASS_ON, 8'h00);
    chk(16'(i2c_en), 16'h1);
    for (int k = 2; k < 6; k++) begin
      icmd(k[2:0], 8'h30 + k[7:0]);
      chk({fv, fcode, fdata}, {4'h0, 1'b1, k[2:0], 8'h30 + k[7:0]});
    end
    icmd(CSL_I2C_PASS_OFF, 8'h00);
    icmd(3'h2, 8'h99);
    iv = 1'b0;
    chk({i2c_en, fv, fcode, fdata}, 16'h0535);
    osm = 1'b1;
    ow = 1'b1;
    for (int k = 0; k < 4; k++) begin
      osel = k[1:0];
      tick();
      chk(16'(otp), 16'(k));
    end
    osm = 1'b0;
    tick();
    ow = 1'b0;
    chk(16'(otp), 16'h0);
    sw = 1'b1;
    tick();
    chk({acc, rej}, 16'h2);
    att = 1'b1;
    tick();
    sw = 1'b0;
    chk({acc, rej}, 16'h1);
  endtask

  task automatic conclude();
    $display("checks=%0d mismatches=%0d", total_checks, n_mismatch);
    if (n_mismatch == 0 && total_checks > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask

  initial begin
    #1000000;
    n_mismatch++;
    conclude();
  end

  initial begin
    t_straps();
    t_select();
    t_commands();
    conclude();
  end
endmodule
